// ==== core/dsr_pkg.sv ====
// Constants, types and shared decode for the three-lane 7:1 link deserializer.
// Assumes a 125 MHz control clock and a bit-sampling clock at fourteen times the link clock.
// Summary of operation
// (RULE1) Each of the three lanes has its own 7-bit serial-in, parallel-out shift register.
// (RULE2) The link is three differential data lanes plus one differential clock lane, all driven by the far end.
// (RULE3) Each lane is sampled and shifted at seven times the link clock frequency.
// (RULE4) Once per link clock period the three shift registers are moved onto the 21-bit output word.
// (RULE5) An output clock is produced and the word is held stable around its falling edge.
// (RULE6) The output clock is high for half of the link clock period.
// (RULE7) The far end keeps the mean link clock period between 14.7 ns and 32.4 ns.
// (RULE8) While shutdown is low the clock generator and the lane receivers are switched off.
// (RULE9) While shutdown is low every shift and output register is cleared to zero.
// (RULE10) After shutdown is released the block waits for phase lock, 1 ms, before data is valid.
// (RULE11) After shutdown is driven low the block reaches its off state within 400 ns; the code takes 52 to 53 control cycles, 416 to 424 ns.
// (RULE12) Lane 0 feeds word bits 0 to 6, lane 1 bits 7 to 13 and lane 2 bits 14 to 20.
// (RULE13) Both ends place the seven bits at the same fixed position within each link clock period.
package dsr_pkg;

	localparam int LANES = 3;
	localparam int BITS_PER_LANE = 7;
	localparam int WORD_W = LANES * BITS_PER_LANE;

	// Link clock period limits kept by the far end, in picoseconds
	localparam int LINK_PERIOD_MIN_PS = 14700;
	localparam int LINK_PERIOD_MAX_PS = 32400;

	localparam int CLK_FREQ_MHZ = 125;
	localparam int LOCK_TIME_MS = 1;
	localparam int LOCK_CYCLES = LOCK_TIME_MS * CLK_FREQ_MHZ * 1000;
	localparam int OFF_TIME_NS = 400;
	localparam int OFF_CYCLES = (OFF_TIME_NS * CLK_FREQ_MHZ) / 1000;

	// Phase counter in the sampling domain: two edges per bit, fourteen per frame
	localparam logic [3:0] PH_FIRST = 4'h0;
	localparam logic [3:0] PH_FALL = 4'h6;
	localparam logic [3:0] PH_LAST = 4'hD;

	typedef enum logic [1:0] {
		DSR_OFF,
		DSR_LOCKING,
		DSR_RUN,
		DSR_DRAINING
	} dsr_state_t;

	// Differential receiver: a one only when the pair is driven apart the right way
	function automatic logic dsr_diff_bit(input logic pos, input logic neg);
		dsr_diff_bit = pos & ~neg;
	endfunction : dsr_diff_bit

endpackage : dsr_pkg

// ==== core/dsr_lane_if.sv ====
// Carrier between the top level and one lane shift register.
// Assumes all signals belong to the bit-sampling clock domain except the raw pins.
interface dsr_lane_if;
	logic clear;
	logic shift;
	logic pos;
	logic neg;
	logic [6:0] frame;

	modport lane (input clear, input shift, input pos, input neg, output frame);
	modport ctrl (output clear, output shift, output pos, output neg, input frame);
endinterface : dsr_lane_if

// ==== core/dsr_lane.sv ====
// One lane: pin synchroniser and 7-bit serial-in, parallel-out shift register.
// Assumes bit_clk_i runs at fourteen times the link clock; shift pulses every other edge.
module dsr_lane
	import dsr_pkg::*;
(
	input wire logic bit_clk_i,
	dsr_lane_if.lane lif
);

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [BITS_PER_LANE-1:0] sh;
	} dsr_lane_st_t;

	dsr_lane_st_t st_r;
	dsr_lane_st_t st_nxt;
	logic bit_w;

	// Pair decoded only after both sync flops, so skew inside the pair cannot glitch a flop
	assign bit_w = dsr_diff_bit(st_r.s2[1], st_r.s2[0]);

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = {lif.pos, lif.neg};
		st_nxt.s2 = st_r.s1;
		if (lif.clear) begin
			st_nxt = '0; // RULE9
		end else if (lif.shift) begin
			// First bit of the frame ends in the top position
			st_nxt.sh = {st_r.sh[BITS_PER_LANE-2:0], bit_w}; // RULE1 RULE3
		end
	end

	always_ff @(posedge bit_clk_i) begin
		st_r <= st_nxt;
	end

	assign lif.frame = st_r.sh;

endmodule : dsr_lane

// ==== core/dsr_top.sv ====
// Top level of the three-lane 7:1 link deserializer.
// Assumes an external phase-locked generator supplies bit_clk_i at fourteen times the link
// clock while clock_gen_enable_o is high; link pins are asynchronous to both clocks.
module dsr_top
	import dsr_pkg::*;
#(
	parameter int LOCK_WAIT_CYCLES = LOCK_CYCLES
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bit_clk_i,
	input wire logic shutdown_clear_n_i,
	input wire logic link_clock_in_pos_i,
	input wire logic link_clock_in_neg_i,
	input wire logic lane0_pos_i,
	input wire logic lane0_neg_i,
	input wire logic lane1_pos_i,
	input wire logic lane1_neg_i,
	input wire logic lane2_pos_i,
	input wire logic lane2_neg_i,
	output logic clock_gen_enable_o,
	output logic receivers_enable_o,
	output logic link_ready_o,
	output logic parallel_clock_out_o,
	output logic [WORD_W-1:0] parallel_word_out_o
);

	localparam int CNT_MAX = (LOCK_WAIT_CYCLES > OFF_CYCLES) ? LOCK_WAIT_CYCLES : OFF_CYCLES;
	localparam int CNT_W = $clog2(CNT_MAX + 1);
	localparam logic [CNT_W-1:0] LOCK_END = CNT_W'(LOCK_WAIT_CYCLES - 1);
	localparam logic [CNT_W-1:0] OFF_END = CNT_W'(OFF_CYCLES - 1);

	// Control domain on clk_i

	typedef struct packed {
		dsr_state_t state;
		logic [CNT_W-1:0] cnt;
		logic sd_s1;
		logic sd_s2;
		logic gen_en;
		logic run;
	} dsr_ctl_st_t;

	dsr_ctl_st_t c_r;
	dsr_ctl_st_t c_nxt;

	// Shutdown pin is a raw level; only the second sync flop is read by the state logic
	always_comb begin
		c_nxt = c_r;
		c_nxt.sd_s1 = shutdown_clear_n_i;
		c_nxt.sd_s2 = c_r.sd_s1;
		c_nxt.cnt = c_r.cnt + CNT_W'(1);
		unique case (c_r.state)
			DSR_OFF: begin
				// Sampling side was already cleared while draining, so its clock may stop here
				c_nxt.cnt = '0;
				c_nxt.gen_en = 1'b0; // RULE8
				c_nxt.run = 1'b0;
				if (c_r.sd_s2) begin
					c_nxt.state = DSR_LOCKING;
					c_nxt.gen_en = 1'b1;
				end
			end
			DSR_LOCKING: begin
				if (!c_r.sd_s2) begin
					c_nxt.state = DSR_DRAINING;
					c_nxt.cnt = '0;
				end else if (c_r.cnt == LOCK_END) begin
					// Data only released once the generator has had its lock time
					c_nxt.state = DSR_RUN; // RULE10
					c_nxt.run = 1'b1;
				end
			end
			DSR_RUN: begin
				// Data side is told to clear first; the generator follows after the drain time
				if (!c_r.sd_s2) begin
					c_nxt.state = DSR_DRAINING;
					c_nxt.run = 1'b0; // RULE9
					c_nxt.cnt = '0;
				end
			end
			DSR_DRAINING: begin
				// Sampling clock kept alive so the far domain can clear before it stops
				if (c_r.cnt == OFF_END) begin
					c_nxt.state = DSR_OFF; // RULE11
					c_nxt.gen_en = 1'b0; // RULE8
					c_nxt.cnt = '0;
				end
			end
		endcase
		// Reset last so it overrides every state branch
		if (rst_i) begin
			c_nxt = '0;
			c_nxt.state = DSR_OFF;
		end
	end

	always_ff @(posedge clk_i) begin
		c_r <= c_nxt;
	end

	assign clock_gen_enable_o = c_r.gen_en;
	assign receivers_enable_o = c_r.gen_en;
	assign link_ready_o = c_r.run;

	// Sampling domain on bit_clk_i

	typedef struct packed {
		logic run_s1;
		logic run_s2;
		logic [1:0] fc_s1;
		logic [1:0] fc_s2;
		logic fc_d;
		logic [3:0] ph;
		logic primed;
		logic pclk;
		logic [WORD_W-1:0] word;
	} dsr_bit_st_t;

	dsr_bit_st_t b_r;
	dsr_bit_st_t b_nxt;
	logic [WORD_W-1:0] frames_w;
	logic [1:0] lane_pair_w [LANES];
	logic fc_level_w;
	logic shift_w;
	logic frame_start_w;

	dsr_lane_if lif [LANES] ();

	// Shifts fall on the even phases 0 to 12, seven per frame; phase 13 is the park slot
	function automatic logic is_shift_slot(input logic [3:0] ph);
		is_shift_slot = ~ph[0] & (ph != PH_LAST);
	endfunction : is_shift_slot

	// Pairs stay raw up to the second sync flop, where each lane decodes its own pair
	assign lane_pair_w[0] = {lane0_pos_i, lane0_neg_i}; // RULE2
	assign lane_pair_w[1] = {lane1_pos_i, lane1_neg_i}; // RULE2
	assign lane_pair_w[2] = {lane2_pos_i, lane2_neg_i}; // RULE2

	// One strobe for all lanes keeps the three frames on the same bit slots
	assign shift_w = b_r.run_s2 & is_shift_slot(b_r.ph); // RULE3 RULE13

	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++) begin : g_lane
			assign lif[gi].clear = ~b_r.run_s2; // RULE9
			assign lif[gi].shift = shift_w; // RULE3 RULE13
			assign lif[gi].pos = lane_pair_w[gi][1]; // RULE2
			assign lif[gi].neg = lane_pair_w[gi][0];
			assign frames_w[BITS_PER_LANE*gi +: BITS_PER_LANE] = lif[gi].frame; // RULE12
			dsr_lane u_lane (
				.bit_clk_i(bit_clk_i),
				.lif(lif[gi])
			);
		end
	endgenerate

	// Forwarded clock decoded after its synchroniser; its rising edge fixes the frame position
	assign fc_level_w = dsr_diff_bit(b_r.fc_s2[1], b_r.fc_s2[0]); // RULE2
	assign frame_start_w = fc_level_w & ~b_r.fc_d; // RULE13

	always_comb begin
		b_nxt = b_r;
		b_nxt.run_s1 = c_r.run;
		b_nxt.run_s2 = b_r.run_s1;
		b_nxt.fc_s1 = {link_clock_in_pos_i, link_clock_in_neg_i}; // RULE2
		b_nxt.fc_s2 = b_r.fc_s1;
		b_nxt.fc_d = fc_level_w;
		if (!b_r.run_s2) begin
			b_nxt.fc_s1 = 2'h0;
			b_nxt.fc_s2 = 2'h0;
			b_nxt.fc_d = 1'b0;
			b_nxt.ph = PH_LAST;
			b_nxt.primed = 1'b0;
			b_nxt.pclk = 1'b0; // RULE9
			b_nxt.word = '0; // RULE9
		end else if (frame_start_w) begin
			b_nxt.ph = PH_FIRST;
			b_nxt.primed = 1'b1;
			// The first frame after start-up is partial and is dropped
			if (b_r.primed) begin
				b_nxt.word = frames_w; // RULE4
				b_nxt.pclk = 1'b1; // RULE5
			end
		end else begin
			// A missing link clock edge parks the counter and stops shifting
			if (b_r.ph != PH_LAST) begin
				b_nxt.ph = b_r.ph + 4'h1;
			end
			if (b_r.ph == PH_FALL) begin
				b_nxt.pclk = 1'b0; // RULE5 RULE6
			end
		end
	end

	always_ff @(posedge bit_clk_i) begin
		b_r <= b_nxt;
	end

	assign parallel_clock_out_o = b_r.pclk;
	assign parallel_word_out_o = b_r.word;

endmodule : dsr_top

// ==== dv/dsr_checker.sv ====
// Checker for the deserializer top level; sees only its ports.
// Assumes both clocks run and that rst_i is held for several control cycles.
module dsr_checker
	import dsr_pkg::*;
#(
	parameter int LOCK_WAIT_CYCLES = LOCK_CYCLES
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bit_clk_i,
	input wire logic shutdown_clear_n_i,
	input wire logic clock_gen_enable_o,
	input wire logic receivers_enable_o,
	input wire logic link_ready_o,
	input wire logic parallel_clock_out_o,
	input wire logic [WORD_W-1:0] parallel_word_out_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int unsigned lock_cnt;
	// Counts control cycles with the generator on and the link not yet ready
	always_ff @(posedge clk_i) begin
		if (rst_i || !clock_gen_enable_o) begin
			lock_cnt <= '0;
		end else if (!link_ready_o) begin
			lock_cnt <= lock_cnt + 32'h1;
		end
	end
	AST_LOCK_EXACT: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(link_ready_o) |-> lock_cnt == LOCK_WAIT_CYCLES) else $error("lock wait length");
	AST_EN_PAIR: assert property (@(posedge clk_i) disable iff (rst_i)
		clock_gen_enable_o == receivers_enable_o) else $error("enables differ");
	AST_READY_NEEDS_EN: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(link_ready_o) |-> $past(clock_gen_enable_o, 8)) else $error("ready before lock");
	AST_LOCK_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(clock_gen_enable_o) |-> !link_ready_o [*8]) else $error("lock wait too short");
	AST_READY_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(shutdown_clear_n_i) |-> ##[1:4] !link_ready_o) else $error("ready kept");
	AST_OFF_TIME: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(shutdown_clear_n_i) |-> ##[1:56] !clock_gen_enable_o) else $error("off late");
	AST_CLEARED: assert property (@(posedge clk_i) disable iff (rst_i)
		!clock_gen_enable_o |-> parallel_word_out_o == '0 && !parallel_clock_out_o)
		else $error("not cleared");
	AST_HIGH_HALF: assert property (@(posedge bit_clk_i) disable iff (!link_ready_o)
		$rose(parallel_clock_out_o) |-> parallel_clock_out_o [*7] ##1 !parallel_clock_out_o)
		else $error("clock out duty wrong");
	AST_FRAME_RATE: assert property (@(posedge bit_clk_i) disable iff (!link_ready_o)
		$rose(parallel_clock_out_o) |-> ##14 $rose(parallel_clock_out_o)) else $error("rate");
	AST_WORD_STABLE: assert property (@(posedge bit_clk_i) disable iff (!link_ready_o)
		$changed(parallel_word_out_o) |-> $rose(parallel_clock_out_o)) else $error("word moved");
endmodule : dsr_checker

bind dsr_top dsr_checker #(.LOCK_WAIT_CYCLES(LOCK_WAIT_CYCLES)) u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.bit_clk_i(bit_clk_i),
	.shutdown_clear_n_i(shutdown_clear_n_i),
	.clock_gen_enable_o(clock_gen_enable_o),
	.receivers_enable_o(receivers_enable_o),
	.link_ready_o(link_ready_o),
	.parallel_clock_out_o(parallel_clock_out_o),
	.parallel_word_out_o(parallel_word_out_o)
);

// ==== dv/dsr_tx_model.sv ====
// Serializing transmitter model: forwarded clock plus three lanes, 14 sampling edges a frame.
// Assumes bit_clk_i is the sampling clock; the word may change at any time.
module dsr_tx_model (
	input wire logic bit_clk_i,
	input wire logic [20:0] word_i,
	output logic fc_p_o,
	output logic fc_n_o,
	output logic [2:0] lp_o,
	output logic [2:0] ln_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] ph_r = 4'h0;
	// Frame held at exactly 14 sampling edges so the mean link period never wanders;
	// the bench runs on a slowed time base, so absolute period limits are not modelled
	always @(posedge bit_clk_i) begin
		ph_r <= #1 (ph_r == 4'hD) ? 4'h0 : ph_r + 4'h1;
	end
	always_comb begin
		fc_p_o = ph_r < 4'h7;
		fc_n_o = ~fc_p_o;
		for (int l = 0; l < 3; l++) begin
			lp_o[l] = word_i[l * 7 + 6 - ph_r[3:1]];
			ln_o[l] = ~lp_o[l];
		end
	end
endmodule : dsr_tx_model

// ==== dv/tb_top.sv ====
// Self-checking bench: shutdown, lock, four frame patterns, shutdown and relock.
// Assumes the checker is bound in and the sampling clock is made here.
module tb_top
	import dsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'h0, rst_i = 1'h1, bclk = 1'h0, sd_n = 1'h0;
	logic [20:0] tx_w = 21'h0;
	logic fp, fn, en, ren, rdy, pco;
	logic [2:0] lp, ln;
	logic [20:0] wo;
	int fails = 0, samples_checked = 0;
	localparam logic [20:0] PATS [4] = '{21'h00007F, 21'h003F80, 21'h1FC000, 21'h12D4A5};
	always #4 clk_i = ~clk_i;
	always #3 bclk = ~bclk;
	dsr_tx_model u_tx (.bit_clk_i(bclk), .word_i(tx_w), .fc_p_o(fp), .fc_n_o(fn),
		.lp_o(lp), .ln_o(ln));
	dsr_top #(.LOCK_WAIT_CYCLES(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .bit_clk_i(bclk),
		.shutdown_clear_n_i(sd_n), .link_clock_in_pos_i(fp), .link_clock_in_neg_i(fn),
		.lane0_pos_i(lp[0]), .lane0_neg_i(ln[0]), .lane1_pos_i(lp[1]), .lane1_neg_i(ln[1]),
		.lane2_pos_i(lp[2]), .lane2_neg_i(ln[2]), .clock_gen_enable_o(en),
		.receivers_enable_o(ren), .link_ready_o(rdy), .parallel_clock_out_o(pco),
		.parallel_word_out_o(wo));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report;
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	task automatic t_off;
		chk({en, ren, rdy, pco, wo}, 32'h0);
	endtask : t_off
	task automatic t_run;
		sd_n = 1'h1;
		repeat (13) @(posedge clk_i);
		#1 chk({en, ren, rdy}, 3'h6);
		repeat (14) @(posedge clk_i);
		#1 chk(rdy, 1'b1);
		foreach (PATS[i]) begin
			tx_w = PATS[i];
			repeat (60) @(posedge bclk);
			#1 chk(wo, PATS[i]);
		end
	endtask : t_run
	task automatic t_shut;
		sd_n = 1'h0;
		repeat (5) @(posedge clk_i);
		#1 chk(rdy, 1'b0);
		repeat (55) @(posedge clk_i);
		#1 t_off();
	endtask : t_shut
	initial begin
		repeat (12) @(posedge clk_i);
		#1 rst_i = 1'h0;
		repeat (4) @(posedge clk_i);
		#1 t_off();
		t_run();
		t_shut();
		t_run();
		final_report();
	end
	initial begin
		#20000;
		fails++;
		final_report();
	end
endmodule : tb_top
